//--- verilog/audio_in_defines.svh
// constants for the serial audio input port
`ifndef AUDIO_IN_DEFINES_SVH
`define AUDIO_IN_DEFINES_SVH
`define FMT_LEFT_JUST 2'h0
`define FMT_I2S 2'h1
`define FMT_RIGHT_JUST 2'h2
`define WLEN_16 2'h0
`define WLEN_18 2'h1
`define WLEN_20 2'h2
`define WLEN_24 2'h3
`define BITS_16 6'h10
`define BITS_18 6'h12
`define BITS_20 6'h14
`define BITS_24 6'h18
`define HALF_FRAME_SCLK 6'h20
`define I2S_MSB_DELAY 6'h01
`define LJ_MSB_DELAY 6'h00
`define WORD_W 24
`define SETTLE_DONE 2'h3
`define CNT_MAX 6'h3F
`endif

//--- verilog/audio_in_pkg.sv
// types for the serial audio input port
`include "audio_in_defines.svh"
package audio_in_pkg;
	typedef enum logic [1:0] {FmtLeftJust, FmtI2s, FmtRightJust, FmtSpare} frame_fmt_e;
	typedef struct packed {
		logic [`WORD_W-1:0] data;
		logic isRight;
	} audio_word_s;
	typedef struct packed {
		logic s1;
		logic s2;
	} sync_pair_s;
endpackage

//--- verilog/pin_sync.sv
// two-flop synchroniser for the serial input pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync
	import audio_in_pkg::*;
#(
	parameter int WIDTH = 3
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} state_s;
	state_s state_reg;
	state_s state_next;
	always_comb begin
		state_next.first = pinIn;
		state_next.second = state_reg.first;
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign pinOut = state_reg.second;
endmodule
`default_nettype wire

//--- verilog/audio_serial_in.sv
// serial audio input port: deserialises stereo words for the encoder
`timescale 1ns/100ps
`default_nettype none
`include "audio_in_defines.svh"
//
// Summary of operation
// RULE1: framing is left-justified, I2S or right-justified, chosen by frameFmt.
// RULE2: word length 16, 18, 20 or 24 bits; exactly that many bits kept.
// RULE3: each data bit is captured on the rising serial clock edge.
// RULE4: right-justified: frame sync high marks left, low marks right.
// RULE5: right-justified MSB follows sync change by 16, 14, 12 or 8 clocks.
// RULE6: right-justified assumes 64 clocks per frame; LSB ends before next change.
// RULE7: I2S is the default whenever no other framing is selected.
// RULE8: I2S: frame sync low marks left, high marks right.
// RULE9: I2S: MSB one clock after sync change, then bits MSB first.
// RULE10: left-justified: frame sync high marks left, low marks right.
// RULE11: left-justified: MSB in the first clock after sync change.
// RULE12: source changes sync and data on falling edge, stable at rising edge.
// RULE13: each finished word is presented tagged left/right before the next completes.
module audio_serial_in
	import audio_in_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic serialClk,
	input wire logic frameSync,
	input wire logic serialData,
	input wire logic [1:0] frameFmt,
	input wire logic [1:0] wordLen,
	output audio_word_s wordOut,
	output logic wordValid
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	// one register holds all state of the port except the pin synchroniser, whose flops sit in pin_sync
	typedef struct packed {
		logic [1:0] settle;
		logic clkPrev;
		logic fsPrev;
		logic [5:0] bitCnt;
		logic [`WORD_W-1:0] shift;
		logic [5:0] taken;
		logic [5:0] wordBits;
		logic [5:0] delayBits;
		logic chanRight;
		logic active;
		audio_word_s word;
		logic valid;
	} state_s;

	state_s state_reg;
	state_s state_next;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] pinsSync;
	logic clkS;
	logic fsS;
	logic dataS;

	// clock, sync and data share one synchroniser so they stay aligned
	pin_sync #(
		.WIDTH(3)
	) syncInst (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pinIn({serialClk, frameSync, serialData}),
		.pinOut(pinsSync)
	);

	assign clkS = pinsSync[2];
	assign fsS = pinsSync[1];
	assign dataS = pinsSync[0];

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// bits per channel word for a length code
	function automatic logic [5:0] word_bits(input logic [1:0] len);
		case (len)
			`WLEN_16: word_bits = `BITS_16;
			`WLEN_18: word_bits = `BITS_18;
			`WLEN_20: word_bits = `BITS_20;
			default: word_bits = `BITS_24;
		endcase
	endfunction

	// framing for a format code; unused codes fall back to I2S
	function automatic frame_fmt_e fmt_of(input logic [1:0] sel);
		case (sel)
			`FMT_LEFT_JUST: fmt_of = FmtLeftJust;
			`FMT_RIGHT_JUST: fmt_of = FmtRightJust;
			default: fmt_of = FmtI2s; // see RULE7
		endcase
	endfunction

	// clock periods from the sync change to the msb
	function automatic logic [5:0] msb_delay(input frame_fmt_e f, input logic [5:0] n);
		case (f)
			FmtLeftJust: msb_delay = `LJ_MSB_DELAY; // see RULE11
			FmtRightJust: msb_delay = 6'(`HALF_FRAME_SCLK - n); // see RULE5 see RULE6
			default: msb_delay = `I2S_MSB_DELAY; // see RULE9
		endcase
	endfunction

	// channel carried by a sync level
	function automatic logic chan_right(input frame_fmt_e f, input logic fs);
		case (f)
			FmtI2s: chan_right = fs; // see RULE8
			default: chan_right = ~fs; // see RULE4 see RULE10
		endcase
	endfunction

	// msb-align a word of n bits in the output field
	function automatic logic [`WORD_W-1:0] align_word(input logic [`WORD_W-1:0] raw,
		input logic [5:0] n);
		align_word = raw << (6'(`WORD_W) - n);
	endfunction

	// true while a bit of the current word falls in this clock period
	function automatic logic bit_due(input logic [5:0] cnt, input logic [5:0] dly,
		input logic [5:0] got, input logic [5:0] n);
		bit_due = (cnt >= dly) && (got < n);
	endfunction

	// one-step count that stops at its top value
	function automatic logic [5:0] sat_inc(input logic [5:0] cnt);
		if (cnt == `CNT_MAX) begin
			sat_inc = cnt;
		end else begin
			sat_inc = 6'(cnt + 6'h01);
		end
	endfunction

	// ----------------------------------------
	// format and length selection
	// ----------------------------------------
	frame_fmt_e fmt;
	logic [5:0] nBits;
	logic [5:0] msbDelay;

	assign fmt = fmt_of(frameFmt); // see RULE1
	assign nBits = word_bits(wordLen); // see RULE2
	assign msbDelay = msb_delay(fmt, nBits); // see RULE5

	// ----------------------------------------
	// serial clock and sync edges
	// ----------------------------------------
	logic settled;
	logic rise;
	logic fsEdge;

	// the first cycles after reset only learn the pin levels, so no false edge follows
	assign settled = state_reg.settle == `SETTLE_DONE;
	assign rise = settled & clkS & ~state_reg.clkPrev; // see RULE3
	assign fsEdge = rise & (fsS != state_reg.fsPrev);

	// ----------------------------------------
	// deserialiser
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.clkPrev = clkS;
		state_next.valid = 1'b0;

		// learn the pin levels while the synchroniser fills
		if (!settled) begin
			state_next.settle = 2'(state_reg.settle + 2'h1);
			state_next.fsPrev = fsS;
		end

		if (rise) begin
			state_next.fsPrev = fsS;
			if (fsEdge) begin
				// format and length are held for the whole word
				state_next.bitCnt = 6'h00;
				state_next.taken = 6'h00;
				state_next.wordBits = nBits; // see RULE2
				state_next.delayBits = msbDelay; // see RULE6
				state_next.active = 1'b1;
				state_next.shift = '0;
				state_next.chanRight = chan_right(fmt, fsS); // see RULE4 see RULE8 see RULE10
			end

			// the sync change is clock period 0, so a zero delay takes its bit at once
			if (state_next.active && bit_due(state_next.bitCnt, state_next.delayBits,
				state_next.taken, state_next.wordBits)) begin
				state_next.shift = {state_next.shift[`WORD_W-2:0], dataS}; // see RULE9
				state_next.taken = sat_inc(state_next.taken);
				if (state_next.taken == state_next.wordBits) begin
					state_next.word.data = align_word(state_next.shift, state_next.wordBits);
					state_next.word.isRight = state_next.chanRight; // see RULE13
					state_next.valid = 1'b1;
					state_next.active = 1'b0;
				end
			end

			// clock periods since the sync change, saturating
			state_next.bitCnt = sat_inc(state_next.bitCnt);
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wordOut = state_reg.word;
	assign wordValid = state_reg.valid;
endmodule
`default_nettype wire

//--- verification/audio_serial_in_properties.sv
// checker for the serial audio input port
`timescale 1ns/100ps
`default_nettype none
module audio_serial_in_properties
	import audio_in_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic frameSync,
	input wire logic [1:0] frameFmt,
	input wire logic [1:0] wordLen,
	input wire audio_word_s wordOut,
	input wire logic wordValid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_gap; wordValid |=> !wordValid [*8]; endproperty
	a_gap: assert property (p_gap) else $error("valid not a lone pulse");
	property p_hold; !wordValid |-> $stable(wordOut); endproperty
	a_hold: assert property (p_hold) else $error("word moved");
	property p_len; wordValid && wordLen == 2'h0 |-> wordOut.data[7:0] == 8'h00; endproperty
	a_len: assert property (p_len) else $error("extra bits");
	property p_lj; wordValid && frameFmt == 2'h0 |-> wordOut.isRight != frameSync; endproperty
	a_lj: assert property (p_lj) else $error("wrong side");
	property p_i2s;
		wordValid && (frameFmt == 2'h1 || frameFmt == 2'h3) |-> wordOut.isRight == frameSync;
	endproperty
	a_i2s: assert property (p_i2s) else $error("wrong side");
	property p_rj; wordValid && frameFmt == 2'h2 |-> wordOut.isRight != frameSync; endproperty
	a_rj: assert property (p_rj) else $error("wrong side");
	cover property (wordValid && frameFmt == 2'h2);
	cover property (wordValid && frameFmt == 2'h0);
	cover property (wordValid && frameFmt == 2'h3);
	cover property (wordValid && wordOut.isRight);
endmodule
bind audio_serial_in audio_serial_in_properties u_chk (.*);
`default_nettype wire

//--- verification/audio_source.sv
// serial audio source model
`timescale 1ns/100ps
`default_nettype none
module audio_source (
	input wire logic mclk,
	output logic serialClk,
	output logic frameSync,
	output logic serialData
);
	initial begin
		serialClk = 1'b1;
		frameSync = 1'b0;
		serialData = 1'b0;
	end
	task automatic slot(input logic fs, input logic d);
		serialClk = 1'b0;
		frameSync = fs;
		serialData = d;
		repeat (4) @(negedge mclk);
		serialClk = 1'b1;
		repeat (4) @(negedge mclk);
	endtask
	// d is the delay of the msb after the sync change
	task automatic frame(input logic [1:0] fmt, input int n, input logic [23:0] l, r);
		int d;
		int k;
		logic lv;
		d = fmt == 2'h0 ? 0 : fmt == 2'h2 ? 32 - n : 1;
		lv = fmt == 2'h0 || fmt == 2'h2;
		slot(!lv, !serialData);
		for (int i = 0; i < 64; i++) begin
			k = i % 32 - d;
			slot(i < 32 ? lv : !lv, k >= 0 && k < n ? (i < 32 ? l[n-1-k] : r[n-1-k]) : !serialData);
		end
	endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// testbench for the serial audio input port
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import audio_in_pkg::*;
;
	logic mclk, sysRst, serialClk, frameSync, serialData, wordValid;
	logic [1:0] frameFmt, wordLen;
	audio_word_s wordOut;
	audio_word_s seen[$];
	int fails, total_checks;
	audio_serial_in u_audio_serial_in (.mclk(mclk), .sys_rst(sysRst), .serialClk(serialClk),
		.frameSync(frameSync), .serialData(serialData), .frameFmt(frameFmt),
		.wordLen(wordLen), .wordOut(wordOut), .wordValid(wordValid));
	audio_source u_audio_source (.mclk(mclk), .serialClk(serialClk), .frameSync(frameSync),
		.serialData(serialData));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(negedge mclk) if (wordValid === 1'b1) seen.push_back(wordOut);
	task automatic check_word(input audio_word_s exp);
		audio_word_s got;
		got = seen.size() > 0 ? seen.pop_front() : 'x;
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL wordOut exp %h got %h", exp, got);
		end
	endtask
	task automatic check_count(input int exp);
		total_checks++;
		if (seen.size() != exp) begin
			fails++;
			$display("FAIL word count exp %0d got %0d", exp, seen.size());
		end
	endtask
	task automatic check_idle();
		total_checks++;
		if ({wordOut, wordValid} !== 26'h0) begin
			fails++;
			$display("FAIL idle outputs exp %h got %h", 26'h0, {wordOut, wordValid});
		end
	endtask
	task automatic send(input logic [1:0] fmt, input int n, input logic [23:0] l, r);
		@(negedge mclk);
		frameFmt = fmt;
		wordLen = n == 24 ? 2'h3 : 2'((n - 16) / 2);
		u_audio_source.frame(fmt, n, l, r);
		repeat (10) @(negedge mclk);
		check_word({24'(l << (24 - n)), 1'b0});
		check_word({24'(r << (24 - n)), 1'b1});
		check_count(0);
	endtask
	task automatic t_lj();
		send(2'h0, 16, 24'h008001, 24'h007FFE);
		send(2'h0, 24, 24'hC00003, 24'h3FFFFC);
	endtask
	task automatic t_i2s();
		send(2'h1, 18, 24'h020001, 24'h01FFFE);
		send(2'h3, 20, 24'h080003, 24'h07FFFC);
	endtask
	task automatic t_reset();
		@(negedge mclk);
		sysRst = 1'b1;
		repeat (2) @(negedge mclk);
		check_idle();
		sysRst = 1'b0;
		repeat (4) @(negedge mclk);
		check_idle();
		send(2'h0, 20, 24'h0ABCDE, 24'h054321);
	endtask
	task automatic t_rj();
		for (int n = 16; n <= 24; n += 2) if (n != 22) send(2'h2, n, 24'h1 << (n - 1) | 1, 24'h5);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		sysRst = 1'b1;
		frameFmt = 2'h1;
		wordLen = 2'h0;
		fails = 0;
		total_checks = 0;
		repeat (12) @(negedge mclk);
		sysRst = 1'b0;
		t_lj();
		t_i2s();
		t_reset();
		t_rj();
		conclude();
	end
endmodule
`default_nettype wire
